// file: intermittent_fault_stage.sv
/*
 * Decision and timing logic of the transient intermittent earth-fault stage,
 * with its four setting groups behind an AXI4-Lite slave.
 * Assumes samples and the block input come from logic on mclk.
 */
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Four independent settings per stage
// - Trip needs all criteria, voltage at trip
// - Hold trip through reset delay 0.06-300 s
// - Peak count accepts 1 to 20
// - Operate delay 0.02-300 s, 0.02 s steps
// - Intermittent time 0.01-300 s, 0.01 s steps
// - Operate timer starts at first peak
// - Count met, delay elapses in window: trip
// - Count short: release when window expires
// - Late final peak in window trips instantly
// - Window expiring before delay releases stage
// - Reject delay shorter than peaks times 10 ms
// - Four selectable setting groups
// - Fixed 0.1 pu peak threshold, 0.05 pu when sensitive
// - Voltage pickup releases below 0.97
// - Instantaneous samples every 625 us
// - Two fixed current sensitivities selectable
// - Start indication is an output
module intermittent_fault_stage
    import ifault_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and synchronous reset.
    input  wire logic        mclk,
    input  wire logic        reset,
    // Sample stream and auto-reclose block.
    input  wire sample_s     sample,
    input  wire logic        block_in,
    // Stage outputs.
    output logic             start_o,
    output logic             trip_o,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    typedef enum logic [1:0] {IDLE, RUN, HOLD} st_e;
    st_e          st_r, st_nxt;           // Sequence state.
    grp_s         grp_r [4];              // Setting groups.
    logic [31:0]  ctrl_r;                 // Control word.
    logic         rej_r;                  // Last group write was refused.
    logic [20:0]  tdiv_r;                 // 10 ms divider.
    logic         tick;                   // One-cycle 10 ms pulse.
    logic [14:0]  op_r, int_r, rst_r;     // Operate, window, reset timers.
    logic [4:0]   pk_r;                   // Peaks counted in this sequence.
    logic         above_r;                // Current was above threshold last sample.
    logic         upick_r;                // Voltage pickup with hysteresis.
    // Active group and decode of the incoming sample.
    grp_s         g;
    wire  [15:0]  cur_mag = sample.cur[15] ? 16'(-sample.cur) : sample.cur;
    wire  [15:0]  lvl     = ctrl_r[CTRL_SENS] ? PEAK_SENS : PEAK_NORM;
    wire          above   = sample.valid && cur_mag >= lvl
                            && (sample.cur[15] == ctrl_r[CTRL_REV]);
    wire          peak    = above && !above_r;
    // Operands are widened before the product so that no tool keeps it at 16 bits.
    wire  [21:0]  u_th    = 22'(g.upct) * 22'(U_PCT_STEP);
    wire  [22:0]  u_x100  = 23'(sample.volt) * 23'(HYST_DEN);
    wire  [28:0]  th_x97  = 29'(u_th) * 29'(HYST_NUM);
    wire          u_on    = {6'h00, sample.volt} >= u_th;
    wire          u_off   = {6'h00, u_x100} < th_x97;
    wire          enabled = ctrl_r[CTRL_EN] && !block_in;
    wire  [4:0]   pk_now  = pk_r + 5'(peak);
    wire          op_done = op_r >= g.op;
    wire          cnt_ok  = pk_now >= g.peaks;
    wire          win_end = tick && !peak && (int_r + 15'h0001 >= g.intm);
    wire          trip_go = cnt_ok && op_done && upick_r;

    assign g = grp_r[ctrl_r[CTRL_GRP +: 2]];
    assign tick = tdiv_r == 21'(TICK_CYCLES - 1);

    // Free-running divider that marks the 10 ms resolution of all timers.
    always_ff @(posedge mclk) begin
        if (reset || tick) tdiv_r <= '0;
        else tdiv_r <= tdiv_r + 21'h000001;
    end

    // Peak edge memory and voltage pickup; release needs a drop below 97 percent.
    always_ff @(posedge mclk) begin
        if (reset) begin
            above_r <= 1'b0;
            upick_r <= 1'b0;
        end else if (sample.valid) begin
            above_r <= above;
            if (u_on) upick_r <= 1'b1;
            else if (u_off) upick_r <= 1'b0;
        end
    end

    // Next state of the sequence.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            IDLE: if (enabled && peak) st_nxt = RUN;
            RUN: begin
                if (!enabled) st_nxt = IDLE;
                else if (trip_go) st_nxt = HOLD;
                else if (win_end) st_nxt = IDLE;
            end
            HOLD: begin
                // The trip is held until the stage is blocked or disabled, or the reset delay runs out with the voltage pickup gone.
                if (!enabled) st_nxt = IDLE;
                else if (tick && !upick_r && rst_r + 15'h0001 >= g.rst) st_nxt = IDLE;
            end
            default: st_nxt = IDLE;
        endcase
    end

    // Counters and timers; every path back to idle clears them.
    always_ff @(posedge mclk) begin
        if (reset || st_nxt == IDLE) begin
            op_r <= '0;
            int_r <= '0;
            rst_r <= '0;
            pk_r <= '0;
        end else begin
            pk_r <= (st_r == RUN || peak) && pk_now <= PEAK_MAX ? pk_now : pk_r;
            if (peak) int_r <= '0;
            else if (tick) int_r <= int_r + 15'h0001;
            if (tick && !op_done) op_r <= op_r + 15'h0001;
            if (st_r != HOLD || upick_r) rst_r <= '0;
            else if (tick) rst_r <= rst_r + 15'h0001;
        end
    end

    // State and outputs are registered.
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= IDLE;
            start_o <= 1'b0;
            trip_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            start_o <= st_nxt != IDLE;
            trip_o <= st_nxt == HOLD;
        end
    end

    // Register bus: write address and data may arrive in either order.
    logic        aw_have_r, w_have_r;
    logic [7:0]  aw_r;
    logic [31:0] w_r;
    wire         do_wr   = aw_have_r && w_have_r && !s_bvalid;
    wire  [7:0]  goff    = aw_r - GRP_BASE;
    wire         is_grp  = aw_r >= GRP_BASE && goff < 8'(4 * GRP_STRIDE) && aw_r[1:0] == 2'b00;
    wire  [1:0]  gidx    = goff[4:3];
    wire         w_full  = &s_wstrb;
    wire         w_ok    = aw_r == CTRL_OFS || is_grp;
    wire  [14:0] n_op    = w_r[14:0];
    wire  [4:0]  n_pk    = w_r[W0_PEAK +: 5];
    wire  [5:0]  n_up    = w_r[W0_UPCT +: 6];
    wire  [14:0] n_rs    = w_r[W1_RST +: 15];
    wire         ok0     = n_pk >= PEAK_MIN && n_pk <= PEAK_MAX
                           && n_op >= OP_MIN && n_op <= T_MAX && !n_op[0]
                           && n_up >= UPCT_MIN && n_up <= UPCT_MAX
                           && n_op >= {10'h000, n_pk};
    wire         ok1     = n_op >= INT_MIN && n_op <= T_MAX
                           && n_rs >= RST_MIN && n_rs <= T_MAX;
    wire         ok_set  = goff[2] ? ok1 : ok0;

    // Capture of address and data, then one response per write.
    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
            aw_r <= '0;
            w_r <= '0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_r <= 1'b1;
                aw_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_r <= 1'b1;
                w_r <= s_wdata;
            end
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= w_ok ? 2'b00 : 2'b10;
            end else if (s_bvalid && s_bready) s_bvalid <= 1'b0;
        end
    end

    // Ready is offered only while the holding register is empty.
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
        end else begin
            s_awready <= !aw_have_r && !(s_awvalid && s_awready);
            s_wready <= !w_have_r && !(s_wvalid && s_wready);
        end
    end

    // Settings store; partial-strobe and out-of-range writes leave the group as it was.
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_r <= CTRL_RST;
            rej_r <= 1'b0;
            for (int i = 0; i < 4; i++) grp_r[i] <= GRP_DEF;
        end else if (do_wr && w_full) begin
            if (aw_r == CTRL_OFS) ctrl_r <= w_r;
            else if (is_grp) begin
                rej_r <= !ok_set;
                if (ok_set && !goff[2]) begin
                    grp_r[gidx].op <= n_op;
                    grp_r[gidx].peaks <= n_pk;
                    grp_r[gidx].upct <= n_up;
                end else if (ok_set) begin
                    grp_r[gidx].intm <= n_op;
                    grp_r[gidx].rst <= n_rs;
                end
            end
        end
    end

    // Read side: one read at a time, data held until taken.
    wire  [7:0]  roff = s_araddr - GRP_BASE;
    wire         r_grp = s_araddr >= GRP_BASE && roff < 8'(4 * GRP_STRIDE)
                         && s_araddr[1:0] == 2'b00;
    grp_s        rg;
    assign rg = grp_r[roff[4:3]];
    wire  [31:0] stat = {23'h0, rej_r, upick_r, pk_r, trip_o, start_o};
    wire  [31:0] rmux = s_araddr == CTRL_OFS ? ctrl_r
                      : s_araddr == STAT_OFS ? stat
                      : !r_grp ? 32'h0
                      : roff[2] ? {1'b0, rg.rst, 1'b0, rg.intm}
                      : {2'b00, rg.upct, 3'b000, rg.peaks, 1'b0, rg.op};
    wire         r_ok = s_araddr == CTRL_OFS || s_araddr == STAT_OFS || r_grp;

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= 2'b00;
        end else begin
            s_arready <= !s_rvalid && !(s_arvalid && s_arready);
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata <= rmux;
                s_rresp <= r_ok ? 2'b00 : 2'b10;
            end else if (s_rvalid && s_rready) s_rvalid <= 1'b0;
        end
    end

    // Checks on the sequence and on the stored settings.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    first_peak_start_a: assert property (st_r == IDLE && enabled && peak |=> start_o)
        else $error("Peak in idle did not start");
    trip_volt_a: assert property ($rose(trip_o) |-> $past(upick_r))
        else $error("Trip without voltage pickup");
    trip_criteria_a: assert property (st_r == RUN && enabled && trip_go |=> trip_o)
        else $error("Criteria met but no trip");
    late_peak_a: assert property (st_r == RUN && enabled && op_done && upick_r && peak
                                  && pk_r + 5'h01 == g.peaks |=> trip_o)
        else $error("Final late peak did not trip");
    window_rel_a: assert property (st_r == RUN && enabled && !trip_go && win_end
                                   |=> !start_o && !trip_o)
        else $error("Window end did not release");
    no_early_trip_a: assert property ($rose(trip_o) |-> $past(op_r) >= $past(g.op))
        else $error("Trip before operate delay");
    release_clear_a: assert property (st_r != IDLE && st_nxt == IDLE
                                      |=> pk_r == 5'h00 && op_r == 15'h0000)
        else $error("Release left counters set");
    hold_trip_a: assert property (trip_o && upick_r && enabled |=> trip_o)
        else $error("Trip dropped with voltage present");
    group_limit_a: assert property (grp_r[gidx].op >= {10'h000, grp_r[gidx].peaks})
        else $error("Stored delay shorter than peak spacing");
    trip_seen_c: cover property (st_r == RUN ##1 st_r == HOLD);
    release_seen_c: cover property (st_r == RUN ##1 st_r == IDLE);
    reject_seen_c: cover property ($rose(rej_r));
endmodule // intermittent_fault_stage

// file: ifault_pkg.sv
/*
 * Shared constants and carrier types for the intermittent earth-fault stage.
 * Assumes a 125 MHz clock and samples scaled so that 1.0 pu equals PU_ONE.
 */
package ifault_pkg;
    // Clock and time base; settings are held in 10 ms units.
    localparam int CLK_MHZ   = 125;
    localparam int TICK_MS   = 10;
    localparam int TICK_CYC  = TICK_MS * 1000 * CLK_MHZ;
    localparam int SAMPLE_US = 625;          // Expected spacing of sample strobes.
    // Per-unit scaling of current and voltage samples.
    localparam logic [15:0] PU_ONE     = 16'h1000;
    localparam logic [15:0] PEAK_NORM  = 16'h019a; // 0.1 pu at 50 Hz.
    localparam logic [15:0] PEAK_SENS  = 16'h00cd; // Sensitive level for small networks.
    localparam logic [15:0] U_PCT_STEP = 16'h0029; // One percent of nominal voltage.
    localparam logic [6:0]  HYST_NUM   = 7'h61;    // Release ratio 97/100.
    localparam logic [6:0]  HYST_DEN   = 7'h64;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;
    localparam logic [7:0] GRP_BASE   = 8'h10;
    localparam logic [7:0] GRP_STRIDE = 8'h08;
    // Control fields.
    localparam int CTRL_EN = 0;
    localparam int CTRL_GRP = 4;   // Two bits wide.
    localparam int CTRL_SENS = 8;
    localparam int CTRL_REV = 9;
    // Group word 0: op[14:0], peaks[20:16], upct[29:24]; word 1: intm[14:0], rst[30:16].
    localparam int W0_PEAK = 16;
    localparam int W0_UPCT = 24;
    localparam int W1_RST = 16;
    // Accepted setting ranges, in 10 ms units where timed.
    localparam logic [4:0]  PEAK_MIN = 5'h01;
    localparam logic [4:0]  PEAK_MAX = 5'h14;
    localparam logic [14:0] OP_MIN   = 15'h0002;
    localparam logic [14:0] T_MAX    = 15'h7530;
    localparam logic [14:0] INT_MIN  = 15'h0001;
    localparam logic [14:0] RST_MIN  = 15'h0006;
    localparam logic [5:0]  UPCT_MIN = 6'h01;
    localparam logic [5:0]  UPCT_MAX = 6'h3c;
    // Reset values of every group and of the control word.
    localparam logic [14:0] OP_RST   = 15'h0010;
    localparam logic [4:0]  PEAK_RST = 5'h02;
    localparam logic [5:0]  UPCT_RST = 6'h0a;
    localparam logic [14:0] INT_RST  = 15'h0014;
    localparam logic [14:0] RST_RST  = 15'h0006;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // One setting group.
    typedef struct packed {
        logic [14:0] op;
        logic [4:0]  peaks;
        logic [5:0]  upct;
        logic [14:0] intm;
        logic [14:0] rst;
    } grp_s;
    // One instantaneous sample pair.
    typedef struct packed {
        logic        valid;
        logic [15:0] cur;   // Residual current, two's complement.
        logic [15:0] volt;  // Residual voltage magnitude.
    } sample_s;
    localparam grp_s GRP_DEF = '{OP_RST, PEAK_RST, UPCT_RST, INT_RST, RST_RST};
endpackage

// file: breaker_model.sv
/* Model of the breaker trip path and of the neighbouring protection stages.
   Assumes trip and start are registered stage outputs on mclk. */
`timescale 1ns/1ps
module breaker_model
    import ifault_pkg::*;
#(
    parameter int OPEN_CYC = 8  // Contact travel time in cycles.
) (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic reset,
    // Stage outputs and the bench's blocking request.
    input  wire logic trip,
    input  wire logic start,
    input  wire logic blk_req,
    // Breaker state and signals shared with other stages.
    output logic      cb_open,
    output logic      backup_blocked,
    output logic      block_o
);
    int cnt;  // Cycles that trip has stood.
    // The breaker opens only once trip has stood long enough to move the contacts.
    always_ff @(posedge mclk) begin
        if (reset || !trip) begin
            cnt <= 0;
        end else if (cnt < OPEN_CYC) begin
            cnt <= cnt + 1;
        end
    end
    assign cb_open = (cnt == OPEN_CYC);
    // The backup voltage stage is held off while this stage has started.
    assign backup_blocked = start;
    // A reclosing stage's start reaches the block input one cycle later.
    always_ff @(posedge mclk) begin
        block_o <= reset ? 1'b0 : blk_req;
    end
endmodule // breaker_model

// file: intermittent_fault_stage_tb_top.sv
/* Self-checking bench for the intermittent earth-fault stage.
   Assumes a 10-cycle timer tick, so one setting unit is 10 clock cycles. */
`timescale 1ns/1ps
module intermittent_fault_stage_tb_top
    import ifault_pkg::*;
;
    logic        mclk = 1'b0, reset = 1'b1, blk_req = 1'b0;
    sample_s     sample = '0;                 // Sample stream into the stage.
    logic        block_in, start_o, trip_o, cb_open, backup_blocked;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] vlev = '0;                   // Voltage carried by each sample.
    logic [31:0] bad [4] = '{32'h0a05_0004, 32'h0a15_0016, 32'h0a02_0011, 32'h0a00_0010};
    int          failures = 0, tests_run = 0;

    // Free-running 125 MHz clock.
    always #4 mclk = ~mclk;

    intermittent_fault_stage #(.TICK_CYCLES(10)) intermittent_fault_stage_i (
        .mclk(mclk), .reset(reset), .sample(sample), .block_in(block_in),
        .start_o(start_o), .trip_o(trip_o),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));

    breaker_model breaker_model_i (
        .mclk(mclk), .reset(reset), .trip(trip_o), .start(start_o), .blk_req(blk_req),
        .cb_open(cb_open), .backup_blocked(backup_blocked), .block_o(block_in));

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Compares a single output bit.
    task automatic chk1(input logic g, input logic e, input string m);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %b", $time, m, g);
        end
    endtask

    // Compares a bus word or response.
    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One sample strobe; the stage takes it at the second edge.
    task automatic smp(input logic [15:0] c);
        @(posedge mclk);
        sample <= '{1'b1, c, vlev};
        @(posedge mclk);
        sample.valid <= 1'b0;
    endtask

    // A peak followed by a quiet sample, so the next peak is a new crossing.
    task automatic pk(input logic [15:0] c);
        smp(c);
        smp(16'h0000);
    endtask

    // Write with address and data offered together; returns the response.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    // Read; data and response are taken at the edge that sees rvalid.
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axr(a, rd, rs);
        chk32(rd, e, "read data");
        chk32({30'h0, rs}, {30'h0, er}, "read resp");
    endtask

    // Blocking clears any sequence; outputs drop within the block latency.
    task automatic unblock();
        blk_req <= 1'b1;
        wt(4);
        chk1(start_o | trip_o, 1'b0, "block release");
        blk_req <= 1'b0;
        wt(2);
    endtask

    // Watchdog sized well above the roughly 1300 cycles the tests need.
    initial begin
        wt(20000);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        wt(3);
        reset <= 1'b0;
        wt(2);
        rchk(CTRL_OFS, CTRL_RST, 2'b00);
        rchk(GRP_BASE, 32'h0a02_0010, 2'b00);
        rchk(GRP_BASE + 8'h1c, 32'h0006_0014, 2'b00);
        rchk(8'hfc, 32'h0, 2'b10);
        axw(8'hfc, 32'h1, rs);
        chk32({30'h0, rs}, 32'h2, "unmapped write");
        $display("test registers done");
        // Two peaks with no voltage: no trip until the voltage comes up.
        pk(16'h1000);
        chk1(start_o, 1'b1, "start on first peak");
        chk1(backup_blocked, 1'b1, "backup blocked");
        wt(75);
        pk(16'h1000);
        wt(100);
        chk1(trip_o, 1'b0, "trip without voltage");
        vlev = 16'h019a;
        smp(16'h0000);
        wt(3);
        chk1(trip_o, 1'b1, "trip at voltage pickup");
        while (cb_open !== 1'b1) wt(1);
        vlev = 16'd398;
        smp(16'h0000);
        wt(100);
        chk1(trip_o, 1'b1, "hysteresis hold");
        vlev = 16'd397;
        smp(16'h0000);
        wt(45);
        chk1(trip_o, 1'b1, "reset delay hold");
        wt(30);
        chk1(trip_o | start_o, 1'b0, "reset delay end");
        $display("test voltage and hold done");
        // Normal trip timed from the first peak.
        vlev = 16'h019a;
        pk(16'h0199);
        chk1(start_o, 1'b0, "below peak level");
        pk(16'h019a);
        wt(75);
        pk(16'h0800);
        wt(55);
        chk1(trip_o, 1'b0, "early trip");
        wt(40);
        chk1(trip_o, 1'b1, "delay from first peak");
        unblock();
        $display("test normal trip done");
        // One peak only: release at the end of the window.
        pk(16'h1000);
        wt(150);
        chk1(start_o, 1'b1, "window running");
        wt(35);
        chk1(trip_o, 1'b0, "short count trip");
        wt(45);
        chk1(start_o, 1'b0, "window release");
        $display("test short count done");
        // Final peak after the delay but inside the window.
        pk(16'h1000);
        wt(170);
        chk1(trip_o, 1'b0, "trip before last peak");
        pk(16'h1000);
        chk1(trip_o, 1'b1, "instant trip");
        unblock();
        $display("test late peak done");
        // Group 1 with a window shorter than the delay.
        axw(GRP_BASE + GRP_STRIDE + 8'h04, 32'h0006_000a, rs);
        chk32({30'h0, rs}, 32'h0, "group write");
        axw(CTRL_OFS, 32'h0000_0011, rs);
        pk(16'h1000);
        wt(18);
        pk(16'h1000);
        wt(140);
        chk1(start_o | trip_o, 1'b0, "window before delay");
        axw(CTRL_OFS, 32'h0000_0101, rs);
        $display("test short window done");
        // Sensitive level picks up a smaller peak.
        pk(16'h0100);
        chk1(start_o, 1'b1, "sensitive start");
        unblock();
        axw(CTRL_OFS, CTRL_RST, rs);
        pk(16'h0100);
        chk1(start_o, 1'b0, "normal level ignores");
        // Reverse direction: only negative current peaks may start the stage.
        axw(CTRL_OFS, 32'h0000_0201, rs);
        pk(16'h1000);
        chk1(start_o, 1'b0, "reverse ignores forward");
        pk(16'hf000);
        chk1(start_o, 1'b1, "reverse start");
        unblock();
        axw(CTRL_OFS, CTRL_RST, rs);
        $display("test sensitivity and direction done");
        // Settings outside range are refused and leave the group intact.
        for (int i = 0; i < 4; i++) begin
            axw(GRP_BASE, bad[i], rs);
            axr(STAT_OFS, rd, rs);
            chk1(rd[8], 1'b1, "refused flag");
            rchk(GRP_BASE, 32'h0a02_0010, 2'b00);
        end
        axw(GRP_BASE, 32'h0a14_0014, rs);
        rchk(GRP_BASE, 32'h0a14_0014, 2'b00);
        axr(STAT_OFS, rd, rs);
        chk1(rd[8], 1'b0, "refused flag cleared");
        $display("test setting limits done");
        stop_test();
    end
endmodule // intermittent_fault_stage_tb_top
